// *** hdl/motor_brake_protection_ctrl.sv ***
// brake, locked-rotor, clock-loss, undervoltage and reset control with register slave
`timescale 1ns/100ps
module motor_brake_protection_ctrl #(
  parameter int unsigned LOCK_CYC     = motor_pkg::LOCK_CYC,
  parameter int unsigned CLEAR_CYC    = motor_pkg::CLEAR_CYC,
  parameter int unsigned SETTLE_CYC   = motor_pkg::SETTLE_CYC,
  parameter int unsigned CLK_LOSS_CYC = motor_pkg::CLK_LOSS_CYC
) (
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  input  wire logic [motor_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [motor_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         stop_sel,
  input  wire logic                         brake_sel,
  input  wire logic                         ref_clk_in,
  input  wire logic                         fg_in,
  input  wire logic [2:0]                   hall_state,
  input  wire logic                         overcurrent,
  input  wire logic [motor_pkg::MV_W-1:0]   supply_mv,
  input  wire logic [motor_pkg::MV_W-1:0]   protect_timer_pin,
  output logic                              phase_u_high_drive,
  output logic                              phase_v_high_drive,
  output logic                              phase_w_high_drive,
  output logic                              phase_u_low_drive,
  output logic                              phase_v_low_drive,
  output logic                              phase_w_low_drive,
  output logic                              speed_lock_flag_n,
  output logic                              irq
);
  localparam int unsigned CW = motor_pkg::CNT_W;
  localparam int unsigned EW = motor_pkg::EV_W;

  motor_pkg::mode_t       state_ff;
  motor_pkg::mode_t       nxt_state;
  logic [CW-1:0]          timer_ff;
  logic [CW-1:0]          clear_cnt_ff;
  logic                   uvlo_ff;
  logic                   lost_q_ff;
  logic                   uvlo_q_ff;
  logic [2:0]             high_ff;
  logic [2:0]             low_ff;
  logic                   lock_flag_n_ff;
  logic                   irq_ff;
  logic                   bypass_ff;
  logic [7:0]             duty_ff;
  logic [EW-1:0]          irq_stat_ff;
  logic [EW-1:0]          irq_mask_ff;
  logic                   awready_ff;
  logic                   wready_ff;
  logic                   aw_have_ff;
  logic                   w_have_ff;
  logic [7:0]             awaddr_ff;
  logic [31:0]            wdata_ff;
  logic                   wstrb0_ff;
  logic                   bvalid_ff;
  logic [1:0]             bresp_ff;
  logic                   arready_ff;
  logic                   rvalid_ff;
  logic [31:0]            rdata_ff;
  logic [1:0]             rresp_ff;

  wire logic              locked;
  wire logic              clk_lost;
  wire logic              pwm_on;
  wire logic              por_active;
  wire logic              hold_off;
  wire logic              nxt_uvlo;
  wire logic              st_run;
  wire logic              st_settle;
  wire logic              st_fault;
  wire logic              brake_act;
  wire logic              lost_eff;
  wire logic              lock_running;
  wire logic              lock_expired;
  wire logic              settle_done;
  wire logic              clear_req;
  wire logic              clear_done;
  wire logic [5:0]        comm;
  wire logic              pwm_gate;
  wire logic [2:0]        nxt_high;
  wire logic [2:0]        nxt_low;
  wire logic [CW-1:0]     nxt_timer;
  wire logic [CW-1:0]     nxt_clear_cnt;
  wire logic [EW-1:0]     events;
  wire logic [EW-1:0]     nxt_irq_stat;
  wire logic              wr_en;
  wire logic              wr_lane0;
  wire logic              wr_hit;
  wire logic              ar_take;
  wire logic              rd_hit;
  wire logic [31:0]       rd_mux;
  wire logic [31:0]       status_word;

  speed_lock_detect #(
    .LOSS_CYC (CLK_LOSS_CYC)
  ) u_lock (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ref_in   (ref_clk_in),
    .fg_in    (fg_in),
    .locked   (locked),
    .clk_lost (clk_lost)
  );

  pwm_gen u_pwm (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .duty    (duty_ff),
    .pwm_on  (pwm_on)
  );

  assign por_active = protect_timer_pin < motor_pkg::POR_MV;
  assign nxt_uvlo = uvlo_ff ? (supply_mv < motor_pkg::UVLO_RISE_MV)
                            : (supply_mv < motor_pkg::UVLO_FALL_MV);
  assign hold_off = por_active || uvlo_ff;

  assign st_run    = (state_ff == motor_pkg::ST_RUN);
  assign st_settle = (state_ff == motor_pkg::ST_SETTLE);
  assign st_fault  = (state_ff == motor_pkg::ST_FAULT);
  // brake acts inside the settle and run states
  assign brake_act = brake_sel && !stop_sel && (st_run || st_settle);
  assign lost_eff  = clk_lost && !bypass_ff;

  // timer runs only while unlocked, driving and not braking, or while settling
  assign lock_running = st_run && !brake_sel && !stop_sel && !bypass_ff && (!locked || lost_eff);
  assign lock_expired = lock_running && (timer_ff == LOCK_CYC - 1);
  assign settle_done  = st_settle && (timer_ff == SETTLE_CYC - 1);
  assign nxt_timer    = (lock_running || (st_settle && !settle_done)) ? timer_ff + 1'b1 : '0;

  // stop or brake held to clear the latched fault
  assign clear_req     = st_fault && (stop_sel || brake_sel);
  assign clear_done    = clear_req && (clear_cnt_ff == CLEAR_CYC - 1);
  assign nxt_clear_cnt = (clear_req && !clear_done) ? clear_cnt_ff + 1'b1 : '0;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      motor_pkg::ST_POR:
        nxt_state = stop_sel ? motor_pkg::ST_STOP : motor_pkg::ST_SETTLE;
      motor_pkg::ST_STOP:
        if (!stop_sel) nxt_state = motor_pkg::ST_SETTLE;
      motor_pkg::ST_SETTLE:
        if (stop_sel) nxt_state = motor_pkg::ST_STOP;
        else if (settle_done) nxt_state = motor_pkg::ST_RUN;
      motor_pkg::ST_RUN:
        if (stop_sel) nxt_state = motor_pkg::ST_STOP;
        else if (lock_expired) nxt_state = motor_pkg::ST_FAULT;
      motor_pkg::ST_FAULT:
        if (clear_done) nxt_state = stop_sel ? motor_pkg::ST_STOP : motor_pkg::ST_RUN;
      default:
        nxt_state = motor_pkg::ST_POR;
    endcase
    if (hold_off) nxt_state = motor_pkg::ST_POR;
  end

  assign comm = motor_pkg::commutate(hall_state);
  // duty only on the high side
  assign pwm_gate = pwm_on && !overcurrent;
  // brake pattern at full duty, limiter ignored
  // clock loss turns the high side off, resumes when it returns
  assign nxt_high = hold_off  ? 3'h0 :
                    brake_act ? 3'h7 :
                    (st_run && !lost_eff) ? (comm[5:3] & {3{pwm_gate}}) : 3'h0;
  assign nxt_low  = (hold_off || brake_act) ? 3'h0 :
                    (st_run || st_fault) ? comm[2:0] : 3'h0;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff     <= motor_pkg::ST_POR;
      timer_ff     <= '0;
      clear_cnt_ff <= '0;
      uvlo_ff      <= 1'b1;
      high_ff      <= 3'h0;
      low_ff       <= 3'h0;
    end else begin
      state_ff     <= nxt_state;
      timer_ff     <= hold_off ? '0 : nxt_timer;
      clear_cnt_ff <= nxt_clear_cnt;
      uvlo_ff      <= nxt_uvlo;
      high_ff      <= nxt_high;
      low_ff       <= nxt_low;
    end
  end

  assign phase_u_high_drive = high_ff[2];
  assign phase_v_high_drive = high_ff[1];
  assign phase_w_high_drive = high_ff[0];
  assign phase_u_low_drive  = low_ff[2];
  assign phase_v_low_drive  = low_ff[1];
  assign phase_w_low_drive  = low_ff[0];

  // sticky events: entry to fault, clock lost, undervoltage
  assign events[motor_pkg::EV_FAULT]    = lock_expired && !hold_off;
  assign events[motor_pkg::EV_CLK_LOST] = lost_eff && !lost_q_ff && st_run;
  assign events[motor_pkg::EV_UVLO]     = nxt_uvlo && !uvlo_q_ff;

  // register writes commit once address and data are both held
  assign wr_en    = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_lane0 = wr_en && wstrb0_ff;
  assign wr_hit   = (awaddr_ff == motor_pkg::REG_CTRL) || (awaddr_ff == motor_pkg::REG_DUTY) ||
                    (awaddr_ff == motor_pkg::REG_STAT) || (awaddr_ff == motor_pkg::REG_IRQS) ||
                    (awaddr_ff == motor_pkg::REG_IRQM);
  // set wins over a write-one clear
  assign nxt_irq_stat = (irq_stat_ff &
                         ~((wr_lane0 && awaddr_ff == motor_pkg::REG_IRQS) ? wdata_ff[EW-1:0]
                                                                           : {EW{1'b0}}))
                        | events;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bypass_ff      <= 1'b0;
      duty_ff        <= motor_pkg::DUTY_RST;
      irq_mask_ff    <= '0;
      irq_stat_ff    <= '0;
      irq_ff         <= 1'b0;
      lost_q_ff      <= 1'b1;
      uvlo_q_ff      <= 1'b1;
      lock_flag_n_ff <= 1'b1;
    end else begin
      if (wr_lane0 && awaddr_ff == motor_pkg::REG_CTRL) bypass_ff <= wdata_ff[motor_pkg::CTRL_BYPASS_BIT];
      if (wr_lane0 && awaddr_ff == motor_pkg::REG_DUTY) duty_ff <= wdata_ff[7:0];
      if (wr_lane0 && awaddr_ff == motor_pkg::REG_IRQM) irq_mask_ff <= wdata_ff[EW-1:0];
      irq_stat_ff    <= nxt_irq_stat;
      irq_ff         <= |(nxt_irq_stat & irq_mask_ff);
      lost_q_ff      <= lost_eff;
      uvlo_q_ff      <= nxt_uvlo;
      lock_flag_n_ff <= !(locked && !hold_off);
    end
  end

  assign speed_lock_flag_n = lock_flag_n_ff;
  assign irq               = irq_ff;

  // axi4-lite write channels
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= motor_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff  <= s_axi_awaddr;
        aw_have_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff  <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
        w_have_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_en) begin
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_hit ? motor_pkg::RESP_OKAY : motor_pkg::RESP_SLVERR;
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // axi4-lite read channels
  assign status_word = {20'h00000, lost_eff, locked, uvlo_ff, por_active, bypass_ff,
                        2'h0, state_ff};
  assign rd_hit  = (s_axi_araddr == motor_pkg::REG_CTRL) || (s_axi_araddr == motor_pkg::REG_DUTY) ||
                   (s_axi_araddr == motor_pkg::REG_STAT) || (s_axi_araddr == motor_pkg::REG_IRQS) ||
                   (s_axi_araddr == motor_pkg::REG_IRQM);
  assign rd_mux  = (s_axi_araddr == motor_pkg::REG_CTRL) ? {31'h00000000, bypass_ff} :
                   (s_axi_araddr == motor_pkg::REG_DUTY) ? {24'h000000, duty_ff} :
                   (s_axi_araddr == motor_pkg::REG_STAT) ? status_word :
                   (s_axi_araddr == motor_pkg::REG_IRQS) ? {29'h00000000, irq_stat_ff} :
                   (s_axi_araddr == motor_pkg::REG_IRQM) ? {29'h00000000, irq_mask_ff} :
                   32'h00000000;
  assign ar_take = s_axi_arvalid && arready_ff;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= motor_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_mux;
      rresp_ff   <= rd_hit ? motor_pkg::RESP_OKAY : motor_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
endmodule

// *** hdl/pwm_gen.sv ***
// free-running pwm comparator with a forced full-on code
`timescale 1ns/100ps
module pwm_gen (
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic [motor_pkg::PWM_W-1:0] duty,
  output logic                           pwm_on
);
  logic [motor_pkg::PWM_W-1:0] cnt_ff;
  logic                        pwm_ff;
  wire  logic                  nxt_pwm;

  assign nxt_pwm = (duty == motor_pkg::DUTY_FULL) || (cnt_ff < duty);
  assign pwm_on  = pwm_ff;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      pwm_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      pwm_ff <= nxt_pwm;
    end
  end
endmodule

// *** hdl/speed_lock_detect.sv ***
// measures reference and fg periods, flags speed lock and a stopped reference
`timescale 1ns/100ps
module speed_lock_detect #(
  parameter int unsigned LOSS_CYC = motor_pkg::CLK_LOSS_CYC
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic ref_in,
  input  wire logic fg_in,
  output logic      locked,
  output logic      clk_lost
);
  localparam int unsigned PW = motor_pkg::PER_W;
  wire  logic [1:0]    sig_in;
  logic [1:0]          prev_ff;
  logic [1:0]          valid_ff;
  logic [PW-1:0]       run_ff [2];
  logic [PW-1:0]       per_ff [2];
  logic                locked_ff;
  logic                lost_ff;
  wire  logic [PW-1:0] diff;
  wire  logic          nxt_locked;
  wire  logic          nxt_lost;

  assign sig_in = {fg_in, ref_in};

  // channel 0 is the reference clock, channel 1 the fg feedback
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      wire logic rise;
      wire logic sat;
      assign rise = sig_in[g] && !prev_ff[g];
      assign sat  = &run_ff[g];
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          prev_ff[g]  <= 1'b0;
          valid_ff[g] <= 1'b0;
          run_ff[g]   <= '0;
          per_ff[g]   <= '0;
        end else begin
          prev_ff[g] <= sig_in[g];
          if (rise) begin
            run_ff[g]   <= '0;
            per_ff[g]   <= run_ff[g];
            valid_ff[g] <= !sat;
          end else if (!sat) begin
            run_ff[g] <= run_ff[g] + 1'b1;
          end else begin
            valid_ff[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign diff = (per_ff[1] > per_ff[0]) ? per_ff[1] - per_ff[0] : per_ff[0] - per_ff[1];
  assign nxt_locked = &valid_ff && !lost_ff &&
                      (diff <= (per_ff[0] >> motor_pkg::LOCK_WIN_SHIFT));
  assign nxt_lost = (32'(run_ff[0]) >= LOSS_CYC - 1);
  assign locked   = locked_ff;
  assign clk_lost = lost_ff;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      locked_ff <= 1'b0;
      lost_ff   <= 1'b1;
    end else begin
      locked_ff <= nxt_locked;
      lost_ff   <= nxt_lost;
    end
  end
endmodule

// *** shared/motor_pkg.sv ***
// constants, types and tables shared by the motor brake and protection logic
package motor_pkg;

  // clock and timing figures
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned CLK_PER_US       = CLK_HZ / 1_000_000;
  localparam int unsigned CLEAR_TIME_US    = 1000;
  localparam int unsigned CLEAR_CYC        = CLEAR_TIME_US * CLK_PER_US;
  localparam int unsigned CLK_LOSS_TIME_US = 1000;
  localparam int unsigned CLK_LOSS_CYC     = CLK_LOSS_TIME_US * CLK_PER_US;
  localparam int unsigned SETTLE_TIME_US   = 10000;
  localparam int unsigned SETTLE_CYC       = SETTLE_TIME_US * CLK_PER_US;
  // protection time is 15.1 s per uF, kept in tenths of a second per uF
  localparam longint unsigned LOCK_DS_PER_UF = 151;
  localparam longint unsigned LOCK_CAP_NF    = 1000;
  localparam longint unsigned LOCK_CYC_L     =
    (LOCK_DS_PER_UF * LOCK_CAP_NF * CLK_HZ) / 64'd10_000;
  localparam int unsigned LOCK_CYC          = int'(LOCK_CYC_L);
  localparam int unsigned CNT_W             = 32;

  // analog levels as millivolt codes
  localparam int unsigned MV_W        = 13;
  localparam logic [12:0] UVLO_FALL_MV = 13'd3740;
  localparam logic [12:0] UVLO_RISE_MV = 13'd3930;
  localparam logic [12:0] POR_MV       = 13'd250;

  // speed lock window is one sixteenth of the reference period
  localparam int unsigned LOCK_WIN_SHIFT = 4;
  localparam int unsigned PER_W          = 24;

  // pwm
  localparam int unsigned PWM_W     = 8;
  localparam logic [7:0]  DUTY_FULL = 8'hFF;
  localparam logic [7:0]  DUTY_RST  = 8'h80;

  // register map, byte addresses
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_DUTY  = 8'h04;
  localparam logic [7:0] REG_STAT  = 8'h08;
  localparam logic [7:0] REG_IRQS  = 8'h0C;
  localparam logic [7:0] REG_IRQM  = 8'h10;
  localparam int unsigned CTRL_BYPASS_BIT = 0;
  localparam int unsigned EV_W           = 3;
  localparam int unsigned EV_FAULT       = 0;
  localparam int unsigned EV_CLK_LOST    = 1;
  localparam int unsigned EV_UVLO        = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_POR    = 5'h01,
    ST_STOP   = 5'h02,
    ST_SETTLE = 5'h04,
    ST_RUN    = 5'h08,
    ST_FAULT  = 5'h10
  } mode_t;

  // six-step table: {high u,v,w, low u,v,w}; equal hall inputs give all off
  function automatic logic [5:0] commutate(input logic [2:0] hall);
    logic [5:0] pat;
    pat = 6'h00;
    case (hall)
      3'h1: pat = 6'h22;
      3'h3: pat = 6'h21;
      3'h2: pat = 6'h11;
      3'h6: pat = 6'h14;
      3'h4: pat = 6'h0C;
      3'h5: pat = 6'h0A;
      default: pat = 6'h00;
    endcase
    return pat;
  endfunction

endpackage

// *** tb/motor_assertions.sv ***
// concurrent checks on the drive outputs of the motor control block
`timescale 1ns/100ps
module motor_checker (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        stop_sel,
  input wire logic        brake_sel,
  input wire logic [2:0]  hall_state,
  input wire logic [12:0] supply_mv,
  input wire logic [12:0] protect_timer_pin,
  input wire logic        phase_u_high_drive,
  input wire logic        phase_v_high_drive,
  input wire logic        phase_w_high_drive,
  input wire logic        phase_u_low_drive,
  input wire logic        phase_v_low_drive,
  input wire logic        phase_w_low_drive
);
  wire [2:0] hi = {phase_u_high_drive, phase_v_high_drive, phase_w_high_drive};
  wire [2:0] lo = {phase_u_low_drive, phase_v_low_drive, phase_w_low_drive};
  wire       ok = (supply_mv >= 13'hF5A) && (protect_timer_pin >= 13'h0FA);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_brake_lows_off: assert property (hi == 3'h7 |-> lo == 3'h0)
    else $error("low side on while all high side on");
  a_brake_full_on: assert property (brake_sel && !stop_sel && ok && hi == 3'h7
    ##1 brake_sel && !stop_sel && ok |-> hi == 3'h7)
    else $error("brake drive dropped");
  a_por_all_off: assert property (protect_timer_pin < 13'h0FA |-> ##2 {hi, lo} == 6'h00)
    else $error("drive on in power-on reset");
  a_uvlo_all_off: assert property (supply_mv < 13'hE9C |-> ##2 {hi, lo} == 6'h00)
    else $error("drive on in undervoltage");
  a_uvlo_hyst: assert property (supply_mv < 13'hE9C ##1 (supply_mv < 13'hF5A)[*3]
    |=> {hi, lo} == 6'h00)
    else $error("lockout released below rising level");
  a_stop_high_off: assert property (stop_sel[*3] |-> hi == 3'h0)
    else $error("high side on in stop");
  a_settle_wait: assert property ($fell(stop_sel) && !brake_sel |=> (hi == 3'h0)[*8])
    else $error("drive began without settling");
  a_hall_same_off: assert property ((hall_state == 3'h0 || hall_state == 3'h7)[*3]
    |-> lo == 3'h0)
    else $error("low side on with equal hall inputs");
endmodule
bind motor_brake_protection_ctrl motor_checker chk_u (.*);

// *** tb/motor_partner.sv ***
// reference clock source and rotor speed feedback
`timescale 1ns/100ps
module motor_partner (
  input  wire logic clk_sys,
  input  wire logic clk_en,
  input  wire logic lock_en,
  output logic      ref_clk_in,
  output logic      fg_in
);
  logic [5:0] ref_cnt_ff = 6'h00;
  logic [5:0] fg_cnt_ff  = 6'h00;
  logic       ref_ff     = 1'b0;
  logic       fg_ff      = 1'b0;
  wire  [5:0] fg_half    = lock_en ? 6'h13 : 6'h1D;
  assign ref_clk_in = ref_ff;
  assign fg_in      = fg_ff;
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      ref_cnt_ff <= (ref_cnt_ff == 6'h13) ? 6'h00 : ref_cnt_ff + 6'h01;
      ref_ff     <= (ref_cnt_ff == 6'h13) ? ~ref_ff : ref_ff;
    end
  end
  always_ff @(posedge clk_sys) begin
    fg_cnt_ff <= (fg_cnt_ff >= fg_half) ? 6'h00 : fg_cnt_ff + 6'h01;
    fg_ff     <= (fg_cnt_ff >= fg_half) ? ~fg_ff : fg_ff;
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the motor control block
`timescale 1ns/100ps
module tb_top;
  logic        clk_sys = 0, nrst = 0, stop_sel = 1, brake_sel = 0, overcurrent = 0;
  logic        clk_en = 1, lock_en = 1, ref_clk_in, fg_in, irq, speed_lock_flag_n;
  logic [2:0]  hall_state = 3'h0;
  logic [12:0] supply_mv = 13'hF6E, protect_timer_pin = 13'h3E8;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        phase_u_high_drive, phase_v_high_drive, phase_w_high_drive;
  logic        phase_u_low_drive, phase_v_low_drive, phase_w_low_drive;
  wire  [5:0]  drv = {phase_u_high_drive, phase_v_high_drive, phase_w_high_drive,
                      phase_u_low_drive, phase_v_low_drive, phase_w_low_drive};
  int          failures = 0, checked = 0, cyc = 0;
  motor_brake_protection_ctrl #(.LOCK_CYC(2000), .CLEAR_CYC(50), .SETTLE_CYC(20),
    .CLK_LOSS_CYC(200)) dut_u (.*);
  motor_partner partner_u (.*);
  always #10 clk_sys = ~clk_sys;
  task results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task t_regs();
    rd(motor_pkg::REG_DUTY);
    chk(rdat, 32'h80);
    wr(motor_pkg::REG_DUTY, 32'hFF);
    chk(resp, motor_pkg::RESP_OKAY);
    rd(motor_pkg::REG_DUTY);
    chk(rdat, 32'hFF);
    rd(8'h40);
    chk(resp, motor_pkg::RESP_SLVERR);
    wr(motor_pkg::REG_IRQS, 32'h7);
    wr(motor_pkg::REG_IRQM, 32'h7);
    wt(2);
    chk(irq, 1'b0);
    $display("regs test done");
  endtask
  task t_brake();
    stop_sel <= 0;
    hall_state <= 3'h1;
    wt(300);
    chk(drv, 6'h22);
    chk(speed_lock_flag_n, 1'b0);
    overcurrent <= 1;
    wt(3);
    chk(drv, 6'h02);
    brake_sel <= 1;
    wt(3);
    chk(drv, 6'h38);
    brake_sel <= 0;
    overcurrent <= 0;
    wt(3);
    chk(drv, 6'h22);
    $display("brake test done");
  endtask
  task t_fault();
    lock_en <= 0;
    wt(1500);
    lock_en <= 1;
    wt(300);
    chk(drv, 6'h22);
    lock_en <= 0;
    wt(1500);
    chk(drv, 6'h22);
    wt(800);
    chk(drv, 6'h02);
    chk(speed_lock_flag_n, 1'b1);
    chk(irq, 1'b1);
    rd(motor_pkg::REG_IRQS);
    chk(rdat, 32'h1);
    wr(motor_pkg::REG_IRQS, 32'h1);
    wt(2);
    chk(irq, 1'b0);
    lock_en <= 1;
    brake_sel <= 1;
    wt(30);
    brake_sel <= 0;
    wt(3);
    chk(drv, 6'h02);
    brake_sel <= 1;
    wt(60);
    brake_sel <= 0;
    wt(5);
    chk(drv, 6'h22);
    $display("fault test done");
  endtask
  task t_clk();
    clk_en <= 0;
    wt(400);
    chk(drv, 6'h02);
    chk(irq, 1'b1);
    clk_en <= 1;
    wt(300);
    chk(drv, 6'h22);
    wr(motor_pkg::REG_CTRL, 32'h1);
    clk_en <= 0;
    wt(400);
    chk(drv, 6'h22);
    clk_en <= 1;
    wr(motor_pkg::REG_CTRL, 32'h0);
    wt(300);
    wr(motor_pkg::REG_IRQS, 32'h7);
    $display("clock test done");
  endtask
  task t_power();
    brake_sel <= 1;
    protect_timer_pin <= 13'h064;
    wt(3);
    chk(drv, 6'h00);
    protect_timer_pin <= 13'h3E8;
    supply_mv <= 13'hE74;
    wt(3);
    chk(drv, 6'h00);
    supply_mv <= 13'hED8;
    wt(50);
    chk(drv, 6'h00);
    rd(motor_pkg::REG_IRQS);
    chk(rdat, 32'h4);
    rd(motor_pkg::REG_STAT);
    chk(rdat, 32'h601);
    supply_mv <= 13'hF6E;
    brake_sel <= 0;
    wt(60);
    chk(drv, 6'h22);
    $display("power test done");
  endtask
  initial begin
    wt(2);
    nrst <= 1;
    t_regs();
    t_brake();
    t_fault();
    t_clk();
    t_power();
    results();
  end
endmodule
